// File: core/epi_top.v
/*
 * External pin interrupt block: three request pins, sense control,
 * sticky flags, enables, level wake-up sampled on watchdog ticks.
 * Assumes one clock mclk at 50 MHz, synchronous active-high rst, pins
 * and watchdog tick asynchronous to mclk, core signals on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "epi_defs.vh"

module epi_top
(
   input  wire       mclk,
   input  wire       rst,
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_r,
   input  wire       ext_request_zero,
   input  wire       ext_request_one,
   input  wire       ext_request_two,
   input  wire       global_irq_en,
   input  wire       irq_ack,
   input  wire [1:0] irq_ack_vec,
   input  wire       sleep_io_off,
   input  wire       wdt_clk,
   output reg        irq_r,
   output reg  [1:0] irq_vec_r,
   output reg        wake_r
);

   // sense mode decode shared by requests zero and one
   function sense_hit;
      input [1:0] mode;
      input       cur;
      input       prev;
      begin
         case (mode)
            `EPI_MODE_ANY:  sense_hit = cur ^ prev;
            `EPI_MODE_FALL: sense_hit = prev & ~cur;
            `EPI_MODE_RISE: sense_hit = cur & ~prev;
            default:        sense_hit = 1'b0;
         endcase
      end
   endfunction

   reg  [7:0] ext_irq_enable_r;
   reg  [7:0] mcu_control_r;
   reg  [7:0] mcu_control_status_r;
   reg  [2:0] flag_r;
   reg  [2:0] flag_nxt;
   reg  [2:0] pin_s1_r;
   reg  [2:0] pin_s2_r;
   reg  [2:0] pin_prev_r;
   reg  [1:0] prime_r;
   reg        wdt_s1_r;
   reg        wdt_s2_r;
   reg        wdt_prev_r;
   reg  [1:0] lvl_cnt_r [0:1];
   reg  [1:0] lvl_cnt_nxt [0:1];
   reg  [2:0] set_ev;
   reg  [2:0] clr_ev;
   reg  [2:0] pend;
   reg  [2:0] taken;
   reg  [1:0] vec_nxt;
   reg  [7:0] rd_nxt;
   reg        wake_nxt;
   reg  [1:0] mode [0:1];
   reg  [1:0] lvl_mode;
   reg  [1:0] lvl_low;
   reg        two_int;
   reg        two_prev_int;
   reg        two_hit;
   integer    i;

   wire       wr_enable   = reg_wr & (reg_addr == `EPI_ADR_ENABLE);
   wire       wr_ctrl     = reg_wr & (reg_addr == `EPI_ADR_CTRL);
   wire       wr_ctrlstat = reg_wr & (reg_addr == `EPI_ADR_CTRLSTAT);
   wire       wr_flags    = reg_wr & (reg_addr == `EPI_ADR_FLAGS);
   wire       wdt_tick    = wdt_s2_r & ~wdt_prev_r;
   wire       edge_ok     = (prime_r == 2'h0);

   // pins and watchdog clock are asynchronous: two flops before use
   // pin levels are read with no direction gating
   always @(posedge mclk)
   begin
      if (rst)
      begin
         pin_s1_r   <= 3'h7;
         pin_s2_r   <= 3'h7;
         pin_prev_r <= 3'h7;
         wdt_s1_r   <= 1'b0;
         wdt_s2_r   <= 1'b0;
         wdt_prev_r <= 1'b0;
         prime_r    <= 2'h3;
      end
      else
      begin
         pin_s1_r   <= {ext_request_two, ext_request_one, ext_request_zero};
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
         wdt_s1_r   <= wdt_clk;
         wdt_s2_r   <= wdt_s1_r;
         wdt_prev_r <= wdt_s2_r;
         // blanks edges until the synchroniser holds real samples
         if (prime_r != 2'h0)
            prime_r <= prime_r - 2'h1;
      end
   end

   // event and level decode
   always @*
   begin
      mode[0] = {mcu_control_r[`EPI_SENSE_ZERO_HI], mcu_control_r[`EPI_SENSE_ZERO_LO]};
      mode[1] = {mcu_control_r[`EPI_SENSE_ONE_HI], mcu_control_r[`EPI_SENSE_ONE_LO]};
      set_ev = 3'h0;
      lvl_mode = 2'h0;
      lvl_low = 2'h0;
      for (i = 0; i < 2; i = i + 1)
      begin
         lvl_mode[i] = (mode[i] == `EPI_MODE_LOW);
         lvl_low[i] = lvl_mode[i] & ~pin_s2_r[i];
         // clocked edge path stops with the I/O clock
         set_ev[i] = edge_ok & ~sleep_io_off
                   & sense_hit(mode[i], pin_s2_r[i], pin_prev_r[i]);
      end
      // input buffer of two is cut in sleep while it is disabled
      two_int = pin_s2_r[2]
              & ~(sleep_io_off & ~ext_irq_enable_r[`EPI_BIT_TWO]);
      two_prev_int = pin_prev_r[2];
      // one clock period is shorter than the minimum pulse width
      if (mcu_control_status_r[`EPI_SENSE_TWO_EDGE_SEL])
         two_hit = two_int & ~two_prev_int;
      else
         two_hit = two_prev_int & ~two_int;
      // runs in every sleep mode, no I/O clock needed
      set_ev[2] = edge_ok & two_hit;
   end

   // power-down level wake: two consecutive low watchdog samples
   always @*
   begin
      wake_nxt = 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
         lvl_cnt_nxt[i] = lvl_cnt_r[i];
         if (!sleep_io_off || !lvl_low[i] || !ext_irq_enable_r[`EPI_BIT_ZERO + i])
            lvl_cnt_nxt[i] = 2'h0;
         else if (wdt_tick && lvl_cnt_r[i] != `EPI_WAKE_SAMPLES)
            lvl_cnt_nxt[i] = lvl_cnt_r[i] + 2'h1;
         if (lvl_cnt_r[i] == `EPI_WAKE_SAMPLES)
            wake_nxt = 1'b1;
      end
      // edge on two also wakes from any sleep mode
      if (sleep_io_off && flag_r[2] && ext_irq_enable_r[`EPI_BIT_TWO])
         wake_nxt = 1'b1;
      if (!sleep_io_off)
         wake_nxt = 1'b0;
   end

   // flags, pending requests and vector choice
   always @*
   begin
      clr_ev = 3'h0;
      if (wr_flags)
      begin
         clr_ev[0] = reg_wdata[`EPI_BIT_ZERO];
         clr_ev[1] = reg_wdata[`EPI_BIT_ONE];
         clr_ev[2] = reg_wdata[`EPI_BIT_TWO];
      end
      if (irq_ack)
      begin
         case (irq_ack_vec)
            `EPI_VEC_ZERO: clr_ev[0] = 1'b1;
            `EPI_VEC_ONE:  clr_ev[1] = 1'b1;
            `EPI_VEC_TWO:  clr_ev[2] = 1'b1;
            default:       clr_ev = clr_ev;
         endcase
      end
      // set wins over a clear in the same cycle
      flag_nxt = (flag_r & ~clr_ev) | set_ev;
      // level mode keeps the flag cleared
      flag_nxt[0] = flag_nxt[0] & ~lvl_mode[0];
      flag_nxt[1] = flag_nxt[1] & ~lvl_mode[1];
      // level request holds while the pin stays low
      // in power-down only once the wake sampling has passed
      pend[0] = flag_r[0]
              | (lvl_low[0] & (~sleep_io_off | wake_r));
      pend[1] = flag_r[1]
              | (lvl_low[1] & (~sleep_io_off | wake_r));
      pend[2] = flag_r[2];
      taken[0] = pend[0] & ext_irq_enable_r[`EPI_BIT_ZERO];
      taken[1] = pend[1] & ext_irq_enable_r[`EPI_BIT_ONE];
      taken[2] = pend[2] & ext_irq_enable_r[`EPI_BIT_TWO];
      taken = taken & {3{global_irq_en}};
      // fixed priority: zero, then one, then two
      if (taken[0])
         vec_nxt = `EPI_VEC_ZERO;
      else if (taken[1])
         vec_nxt = `EPI_VEC_ONE;
      else if (taken[2])
         vec_nxt = `EPI_VEC_TWO;
      else
         vec_nxt = `EPI_VEC_NONE;
   end

   // read mux; data appear in the cycle after the read strobe
   always @*
   begin
      rd_nxt = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            `EPI_ADR_ENABLE:   rd_nxt = ext_irq_enable_r;
            `EPI_ADR_CTRL:     rd_nxt = mcu_control_r;
            `EPI_ADR_CTRLSTAT: rd_nxt = mcu_control_status_r;
            `EPI_ADR_FLAGS:
            begin
               rd_nxt[`EPI_BIT_ZERO] = flag_r[0];
               rd_nxt[`EPI_BIT_ONE]  = flag_r[1];
               rd_nxt[`EPI_BIT_TWO]  = flag_r[2];
            end
            default:           rd_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         ext_irq_enable_r     <= `EPI_ENABLE_RST;
         mcu_control_r        <= `EPI_CTRL_RST;
         mcu_control_status_r <= `EPI_CTRLSTAT_RST;
         flag_r               <= 3'h0;
         lvl_cnt_r[0]         <= 2'h0;
         lvl_cnt_r[1]         <= 2'h0;
         reg_rdata_r          <= 8'h00;
         irq_r                <= 1'b0;
         irq_vec_r            <= `EPI_VEC_NONE;
         wake_r               <= 1'b0;
      end
      else
      begin
         if (wr_enable)
            ext_irq_enable_r <= reg_wdata & `EPI_ENABLE_WMASK;
         if (wr_ctrl)
            mcu_control_r <= reg_wdata;
         // software should disable two before changing the edge
         if (wr_ctrlstat)
            mcu_control_status_r <= reg_wdata;
         flag_r       <= flag_nxt;
         lvl_cnt_r[0] <= lvl_cnt_nxt[0];
         lvl_cnt_r[1] <= lvl_cnt_nxt[1];
         reg_rdata_r  <= rd_nxt;
         irq_r        <= (vec_nxt != `EPI_VEC_NONE);
         irq_vec_r    <= vec_nxt;
         wake_r       <= wake_nxt;
      end
   end

endmodule
`default_nettype wire

// File: core/epi_defs.vh
/*
 * Register map, field positions, reset values, sense modes and timing
 * constants of the external pin interrupt block.
 * Assumes inclusion by bare name from core/ design files.
 */
`ifndef EPI_DEFS_VH
`define EPI_DEFS_VH

// register indices on the plain register port
`define EPI_ADR_ENABLE   3'h0
`define EPI_ADR_CTRL     3'h1
`define EPI_ADR_CTRLSTAT 3'h2
`define EPI_ADR_FLAGS    3'h3

// enable and flag bit positions
`define EPI_BIT_ONE      7
`define EPI_BIT_ZERO     6
`define EPI_BIT_TWO      5

// sense control field positions
`define EPI_SENSE_ONE_HI 3
`define EPI_SENSE_ONE_LO 2
`define EPI_SENSE_ZERO_HI 1
`define EPI_SENSE_ZERO_LO 0
`define EPI_SENSE_TWO_EDGE_SEL 6

// writable masks of the enable and flag registers
`define EPI_ENABLE_WMASK 8'hE3
`define EPI_FLAGS_MASK   8'hE0

// reset values
`define EPI_ENABLE_RST   8'h00
`define EPI_CTRL_RST     8'h00
`define EPI_CTRLSTAT_RST 8'h00
`define EPI_FLAGS_RST    8'h00

// sense modes
`define EPI_MODE_LOW     2'h0
`define EPI_MODE_ANY     2'h1
`define EPI_MODE_FALL    2'h2
`define EPI_MODE_RISE    2'h3

// vector codes, one per request
`define EPI_VEC_NONE     2'h0
`define EPI_VEC_ZERO     2'h1
`define EPI_VEC_ONE      2'h2
`define EPI_VEC_TWO      2'h3

// timing
`define EPI_CLK_NS       20
`define EPI_T_INT_NS     50
`define EPI_T_INT_CYC    ((`EPI_T_INT_NS / `EPI_CLK_NS) < 1 ? 1 : (`EPI_T_INT_NS / `EPI_CLK_NS))
`define EPI_WAKE_SAMPLES 2'h2

`endif

// File: verification/epi_top_asserts.sv
/* port checker for epi_top.
   assumes one clock mclk and a synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module epi_chk
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [2:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic       global_irq_en,
   input wire logic       sleep_io_off,
   input wire logic       irq_r,
   input wire logic [1:0] irq_vec_r,
   input wire logic       wake_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence rd_of(logic [2:0] a);
      $past(reg_rd) && $past(reg_addr) == a;
   endsequence
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
      else $error("read data outside read slot");
   chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 3'h3
      |-> reg_rdata_r == 8'h00)
      else $error("unmapped read not zero");
   chk_enable_mask: assert property (rd_of(3'h0) |-> reg_rdata_r[4:2] == 3'h0)
      else $error("enable reserved bits set");
   chk_flag_mask: assert property (rd_of(3'h3) |-> reg_rdata_r[4:0] == 5'h00)
      else $error("flag reserved bits set");
   chk_gie_gate: assert property (irq_r |-> $past(global_irq_en))
      else $error("interrupt without global enable");
   chk_vec_pairs: assert property (irq_r == (irq_vec_r != 2'h0))
      else $error("vector and interrupt disagree");
   chk_wake_sleep: assert property (wake_r |-> $past(sleep_io_off))
      else $error("wake outside sleep");
   chk_reset_quiet: assert property ($fell(rst) |-> !irq_r && !wake_r && irq_vec_r == 2'h0)
      else $error("outputs active after reset");
endmodule
bind epi_top epi_chk epi_chk_inst (.mclk, .rst, .reg_addr, .reg_rd, .reg_rdata_r,
   .global_irq_en, .sleep_io_off, .irq_r, .irq_vec_r, .wake_r);
`default_nettype wire

// File: verification/epi_src.sv
/* model of the sources driving the three request pins and the
   watchdog oscillator. assumes pins idle high. */
`timescale 1ns/1ps
`default_nettype none
module epi_src
(
   output logic [2:0] pin,
   output logic       wdt_clk
);
   initial pin = 3'h7;
   initial wdt_clk = 1'b0;
   // free running, period unrelated to mclk
   always #173 wdt_clk = ~wdt_clk;
   // pad level; low level is held until the caller releases it
   task drive(input int i, input logic v);
      #3 pin[i] = v;
   endtask
endmodule
`default_nettype wire

// File: verification/epi_top_bench.sv
/* self-checking bench for epi_top over its register port.
   assumes the checker is bound and epi_src drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module epi_top_bench;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       gie = 1'b0;
   logic       irq_ack = 1'b0;
   logic [1:0] irq_ack_vec = 2'h0;
   logic       sleep = 1'b0;
   logic [7:0] fb;
   wire  [2:0] pin;
   wire        wdt_clk;
   wire  [7:0] rdata;
   wire        irq;
   wire  [1:0] vec;
   wire        wake;
   int         errors = 0;
   int         num_checks = 0;
   int         s;
   int         m;
   int         i;
   always #10 mclk = ~mclk;
   epi_src epi_src_inst (.pin(pin), .wdt_clk(wdt_clk));
   epi_top epi_top_inst (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r(rdata), .ext_request_zero(pin[0]), .ext_request_one(pin[1]),
      .ext_request_two(pin[2]), .global_irq_en(gie), .irq_ack, .irq_ack_vec,
      .sleep_io_off(sleep), .wdt_clk, .irq_r(irq), .irq_vec_r(vec), .wake_r(wake));
   task summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // hang guard
   initial
   begin
      #200000 errors++;
      summarize();
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++)
         rd(i[2:0], 8'h00);
      wr(3'h0, 8'hFF);
      rd(3'h0, 8'hE3);
      wr(3'h1, 8'h0F);
      rd(3'h1, 8'h0F);
      wr(3'h2, 8'h40);
      rd(3'h2, 8'h40);
      wr(3'h0, 8'h00);
      // one edge at a time, so each edge mode shows which edge it takes
      for (s = 0; s < 3; s++)
         for (m = (s == 2) ? 2 : 1; m < 4; m++)
         begin
            fb = (s == 0) ? 8'h40 : (s == 1) ? 8'h80 : 8'h20;
            if (s < 2)
               wr(3'h1, 8'(m << (2 * s)));
            else
               wr(3'h2, (m == 3) ? 8'h40 : 8'h00);
            wr(3'h3, 8'hE0);
            epi_src_inst.drive(s, 1'b0);
            cyc(6);
            rd(3'h3, (m != 3) ? fb : 8'h00);
            wr(3'h3, 8'hE0);
            epi_src_inst.drive(s, 1'b1);
            cyc(6);
            rd(3'h3, (m != 2) ? fb : 8'h00);
         end
      wr(3'h0, 8'h20);
      gie <= 1'b1;
      cyc(2);
      chk({5'h0, irq, vec}, 8'h07);
      wr(3'h3, 8'hE0);
      cyc(2);
      chk({5'h0, irq, vec}, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h40);
      epi_src_inst.drive(0, 1'b0);
      cyc(6);
      rd(3'h3, 8'h00);
      chk({5'h0, irq, vec}, 8'h05);
      epi_src_inst.drive(0, 1'b1);
      cyc(6);
      chk({5'h0, irq, vec}, 8'h00);
      wr(3'h1, 8'h08);
      wr(3'h3, 8'hE0);
      wr(3'h0, 8'h80);
      gie <= 1'b0;
      epi_src_inst.drive(1, 1'b0);
      cyc(6);
      chk({5'h0, irq, vec}, 8'h00);
      @(posedge mclk);
      gie <= 1'b1;
      cyc(2);
      chk({5'h0, irq, vec}, 8'h06);
      @(posedge mclk);
      irq_ack <= 1'b1;
      irq_ack_vec <= 2'h2;
      @(posedge mclk);
      irq_ack <= 1'b0;
      cyc(2);
      rd(3'h3, 8'h00);
      chk({5'h0, irq, vec}, 8'h00);
      epi_src_inst.drive(1, 1'b1);
      wr(3'h1, 8'h02);
      wr(3'h3, 8'hE0);
      wr(3'h0, 8'h40);
      sleep <= 1'b1;
      epi_src_inst.drive(0, 1'b0);
      cyc(6);
      rd(3'h3, 8'h00);
      epi_src_inst.drive(0, 1'b1);
      wr(3'h1, 8'h00);
      epi_src_inst.drive(0, 1'b0);
      for (i = 0; i < 80 && wake !== 1'b1; i++)
         @(posedge mclk);
      #1 chk({7'h0, wake}, 8'h01);
      if (i == 80)
         summarize();
      epi_src_inst.drive(0, 1'b1);
      @(posedge mclk);
      sleep <= 1'b0;
      cyc(4);
      summarize();
   end
endmodule
`default_nettype wire
